// >>> rtl/pager_packet_map.vh
`ifndef PAGER_PACKET_MAP_VH
`define PAGER_PACKET_MAP_VH
// Packet identifiers (top byte)
`define STATUS_TOP_BYTE 8'h7F
`define IDENT_TOP_BYTE 8'hFF
// Frame word positions that may carry a message word
`define MSG_INDEX_MIN 7'h03
`define MSG_INDEX_MAX 7'h57
// Error bit of a vector packet
`define VEC_ERROR_BIT 23
// Minute timebase
`define MINUTE_SECONDS 36'd60
`define CORE_CLK_MHZ 36'd250
`define HZ_PER_MHZ 36'd1000000
// Serial word length
`define PACKET_BITS 6'h20
// Transmit buffer defaults
`define TXQ_DEPTH_DEFAULT 8
`define TXQ_ADDR_DEFAULT 3
`endif

// >>> rtl/packet_shift_out.v
`include "pager_packet_map.vh"

module packet_shift_out
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Synchronised serial link levels
  input wire sck_level,
  input wire select_n_level,
  // Word to send, taken at select
  input wire [31:0] load_word,
  // Link outputs
  output reg miso_q,
  output wire miso_oe,
  // Events
  output wire word_start,
  output wire word_done
);

reg sck_prev_q;
reg select_prev_q;
reg [31:0] shift_q;
reg [5:0] bit_count_q;

wire sck_rise;
wire sck_fall;

// Edge detection on the already synchronised levels
assign sck_rise = sck_level & ~sck_prev_q & ~select_n_level;
assign sck_fall = ~sck_level & sck_prev_q & ~select_n_level;
assign word_start = select_prev_q & ~select_n_level;
assign word_done = sck_rise & (bit_count_q == `PACKET_BITS - 6'h01);
assign miso_oe = ~select_n_level; // Released between words so other slaves may share the line

// Mode 0: MSB first, host samples on rising edge, next bit driven on falling edge
always @(posedge core_clk)
begin
  if (rst)
  begin
    sck_prev_q <= 1'b0;
    select_prev_q <= 1'b1;
    shift_q <= 32'h00000000;
    bit_count_q <= 6'h00;
    miso_q <= 1'b0;
  end
  else
  begin
    sck_prev_q <= sck_level;
    select_prev_q <= select_n_level;
    if (word_start)
    begin
      shift_q <= {load_word[30:0], 1'b0};
      miso_q <= load_word[31];
      bit_count_q <= 6'h00;
    end
    else
    begin
      if (sck_rise)
        bit_count_q <= bit_count_q + 6'h01;
      if (sck_fall)
      begin
        miso_q <= shift_q[31];
        shift_q <= {shift_q[30:0], 1'b0};
      end
    end
  end
end

endmodule

// >>> rtl/pager_host_packet_status.v
`include "pager_packet_map.vh"

module pager_host_packet_status
#(
  parameter TXQ_DEPTH = `TXQ_DEPTH_DEFAULT,
  parameter TXQ_ADDR = `TXQ_ADDR_DEFAULT,
  parameter [35:0] MINUTE_CYCLES = `MINUTE_SECONDS * `CORE_CLK_MHZ * `HZ_PER_MHZ,
  parameter [1:0] MODEL_VALUE = 2'h2, // Arbitrary value
  parameter [13:0] COMPAT_VALUE = 14'h0ABC, // Arbitrary value
  parameter [7:0] REVISION_VALUE = 8'h5A // Arbitrary value
)
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Serial link pins from the host
  input wire spi_sck,
  input wire spi_cs_n,
  output wire spi_miso,
  output wire spi_miso_oe,
  output reg read_prompt_q,
  // Vector packets from the decoder
  input wire vec_valid,
  input wire [31:0] vec_packet,
  input wire vec_has_msgs,
  // Message words from the decoder
  input wire msg_valid,
  input wire [6:0] word_index,
  input wire [20:0] msg_info,
  input wire msg_errors_gt2,
  // Frame and sync events
  input wire sync_gained,
  input wire sync_lost,
  input wire search_window_expired,
  input wire frame_info_good,
  input wire block0_end,
  input wire [6:0] frame_number_in,
  input wire [3:0] cycle_number_in,
  // Low supply detector
  input wire low_supply_input,
  input wire supply_sample_strobe,
  // Control and configuration
  input wire checksum_pass,
  input wire turn_on_req,
  input wire turn_off_req,
  input wire sync_prompt_enable,
  input wire minute_prompt_enable,
  input wire supply_polarity_select,
  output reg decoding_on_q,
  output reg enabled_q
);

localparam SRC_IDENT = 2'h0;
localparam SRC_QUEUE = 2'h1;
localparam SRC_STATUS = 2'h2;

// Message index window check, used by the message push path only, not by the message gate
function index_in_range;
  input [6:0] idx;
  begin
    index_in_range = (idx >= `MSG_INDEX_MIN) && (idx <= `MSG_INDEX_MAX);
  end
endfunction

// Pin synchronisers; first stage read only by second stage
reg sck_meta_q;
reg sck_sync_q;
reg cs_meta_q;
reg cs_sync_q;
reg supply_meta_q;
reg supply_sync_q;

always @(posedge core_clk)
begin
  if (rst)
  begin
    sck_meta_q <= 1'b0;
    sck_sync_q <= 1'b0;
    cs_meta_q <= 1'b1;
    cs_sync_q <= 1'b1;
    supply_meta_q <= 1'b0;
    supply_sync_q <= 1'b0;
  end
  else
  begin
    sck_meta_q <= spi_sck;
    sck_sync_q <= sck_meta_q;
    cs_meta_q <= spi_cs_n;
    cs_sync_q <= cs_meta_q;
    supply_meta_q <= low_supply_input;
    supply_sync_q <= supply_meta_q;
  end
end

// Status state
reg frame_info_valid;
reg fi_seen_q;
reg [6:0] frame_number_q;
reg [3:0] cycle_number_q;
reg sync_mode_flag;
reg low_supply_level;
reg prev_sample_q;
reg have_sample_q;
reg sync_change_flag;
reg first_sync_done_q;
reg supply_change_flag;
reg minute_tick_flag;
reg overflow_flag;
reg [35:0] minute_count_q;
reg msg_gate_q;

// Transmit buffer
reg [31:0] txq_mem [0:TXQ_DEPTH-1];
reg [TXQ_ADDR-1:0] txq_wr_q;
reg [TXQ_ADDR-1:0] txq_rd_q;
reg [TXQ_ADDR:0] txq_count_q;

// Word in flight
reg [1:0] source_q;
reg [3:0] sent_flags_q;

wire word_start;
wire word_done;
wire minute_event;
wire turn_on_ok;
wire turn_off;
wire txq_empty;
wire txq_full;
wire push_vec;
wire push_msg;
wire push;
wire overflow;
wire pop;
wire status_read;
wire [31:0] push_word;
wire [31:0] status_word;
wire [31:0] ident_word;
reg [31:0] load_word;
reg [1:0] source_d;

// Packet assembly
assign status_word = {`STATUS_TOP_BYTE,
                      frame_info_valid, frame_number_q,
                      sync_mode_flag, low_supply_level, 2'b00, cycle_number_q,
                      sync_change_flag, supply_change_flag, 1'b0, minute_tick_flag,
                      3'b000, overflow_flag};
assign ident_word = {`IDENT_TOP_BYTE, MODEL_VALUE, COMPAT_VALUE, REVISION_VALUE};

// Message packets only follow an error-free vector announcing words
assign push_vec = vec_valid & decoding_on_q;
assign push_msg = msg_valid & decoding_on_q & msg_gate_q & index_in_range(word_index) & ~vec_valid;
assign push = push_vec | push_msg;
assign push_word = vec_valid ? vec_packet : {1'b0, word_index, msg_errors_gt2, 2'b00, msg_info};

assign txq_empty = (txq_count_q == {(TXQ_ADDR+1){1'b0}});
assign txq_full = (txq_count_q == TXQ_DEPTH[TXQ_ADDR:0]);
assign overflow = push & txq_full & ~pop;
assign pop = word_done & (source_q == SRC_QUEUE) & ~txq_empty;
assign status_read = word_done & (source_q == SRC_STATUS);

assign turn_on_ok = turn_on_req & enabled_q & ~decoding_on_q;
assign turn_off = decoding_on_q & (turn_off_req | overflow);
assign minute_event = (minute_count_q == MINUTE_CYCLES - 36'h000000001);

// Choose the packet at the start of each host read
always @*
begin
  if (!enabled_q)
  begin
    source_d = SRC_IDENT;
    load_word = ident_word;
  end
  else if (!txq_empty)
  begin
    source_d = SRC_QUEUE;
    load_word = txq_mem[txq_rd_q];
  end
  else
  begin
    source_d = SRC_STATUS;
    load_word = status_word;
  end
end

// Serial shifter
packet_shift_out u_shift
(
  .core_clk(core_clk),
  .rst(rst),
  .sck_level(sck_sync_q),
  .select_n_level(cs_sync_q),
  .load_word(load_word),
  .miso_q(spi_miso),
  .miso_oe(spi_miso_oe),
  .word_start(word_start),
  .word_done(word_done)
);

// Track which kind of word is on the line and which flags it showed
always @(posedge core_clk)
begin
  if (rst)
  begin
    source_q <= SRC_IDENT;
    sent_flags_q <= 4'h0;
  end
  else if (word_start)
  begin
    source_q <= source_d;
    sent_flags_q <= {sync_change_flag, supply_change_flag, minute_tick_flag, overflow_flag};
  end
end

// Transmit buffer; overflow empties it rather than dropping silently
always @(posedge core_clk)
begin
  if (rst)
  begin
    txq_wr_q <= {TXQ_ADDR{1'b0}};
    txq_rd_q <= {TXQ_ADDR{1'b0}};
    txq_count_q <= {(TXQ_ADDR+1){1'b0}};
  end
  else if (overflow || turn_off_req)
  begin
    txq_wr_q <= {TXQ_ADDR{1'b0}};
    txq_rd_q <= {TXQ_ADDR{1'b0}};
    txq_count_q <= {(TXQ_ADDR+1){1'b0}};
  end
  else
  begin
    if (push)
    begin
      txq_mem[txq_wr_q] <= push_word;
      txq_wr_q <= (txq_wr_q == TXQ_DEPTH[TXQ_ADDR-1:0] - 1'b1) ? {TXQ_ADDR{1'b0}} : txq_wr_q + 1'b1;
    end
    if (pop)
      txq_rd_q <= (txq_rd_q == TXQ_DEPTH[TXQ_ADDR-1:0] - 1'b1) ? {TXQ_ADDR{1'b0}} : txq_rd_q + 1'b1;
    if (push && !pop)
      txq_count_q <= txq_count_q + 1'b1;
    else if (pop && !push)
      txq_count_q <= txq_count_q - 1'b1;
  end
end

// Decoder enable and on/off control
always @(posedge core_clk)
begin
  if (rst)
  begin
    enabled_q <= 1'b0;
    decoding_on_q <= 1'b0;
  end
  else
  begin
    if (checksum_pass)
      enabled_q <= 1'b1;
    if (turn_off)
      decoding_on_q <= 1'b0;
    else if (turn_on_ok)
      decoding_on_q <= 1'b1;
  end
end

// Message gate opens on a good vector that has words, closes each frame
always @(posedge core_clk)
begin
  if (rst)
    msg_gate_q <= 1'b0;
  else if (vec_valid)
    msg_gate_q <= ~vec_packet[`VEC_ERROR_BIT] & vec_has_msgs;
  else if (block0_end || turn_off)
    msg_gate_q <= 1'b0;
end

// Frame info and counters
always @(posedge core_clk)
begin
  if (rst)
  begin
    frame_info_valid <= 1'b0;
    fi_seen_q <= 1'b0;
    frame_number_q <= 7'h00;
    cycle_number_q <= 4'h0;
  end
  else if (turn_off || sync_lost)
  begin
    frame_info_valid <= 1'b0;
    fi_seen_q <= 1'b0;
  end
  else
  begin
    if (frame_info_good && sync_mode_flag)
      fi_seen_q <= 1'b1;
    if (block0_end)
    begin
      frame_number_q <= frame_number_in;
      cycle_number_q <= cycle_number_in;
      if (fi_seen_q || frame_info_good)
        frame_info_valid <= 1'b1;
    end
  end
end

// Sync mode and its change flag; set beats clear-on-read
always @(posedge core_clk)
begin
  if (rst)
  begin
    sync_mode_flag <= 1'b0;
    sync_change_flag <= 1'b0;
    first_sync_done_q <= 1'b0;
  end
  else
  begin
    if (turn_off)
    begin
      sync_mode_flag <= 1'b0;
      first_sync_done_q <= 1'b0;
    end
    else if (turn_on_ok)
      first_sync_done_q <= 1'b0;
    else if (decoding_on_q)
    begin
      if (sync_gained)
        sync_mode_flag <= 1'b1;
      else if (sync_lost)
        sync_mode_flag <= 1'b0;
      if (sync_gained || (search_window_expired && !first_sync_done_q))
        first_sync_done_q <= 1'b1;
    end
    if (decoding_on_q && !turn_off &&
        ((!first_sync_done_q && (sync_gained || search_window_expired)) ||
         (first_sync_done_q && ((sync_gained && !sync_mode_flag) || (sync_lost && sync_mode_flag)))))
      sync_change_flag <= 1'b1;
    else if (status_read && sent_flags_q[3])
      sync_change_flag <= 1'b0;
  end
end

// Low supply sampling
always @(posedge core_clk)
begin
  if (rst)
  begin
    low_supply_level <= 1'b0;
    prev_sample_q <= 1'b0;
    have_sample_q <= 1'b0;
    supply_change_flag <= 1'b0;
  end
  else
  begin
    if (supply_sample_strobe)
    begin
      low_supply_level <= supply_sync_q;
      prev_sample_q <= supply_sync_q;
      have_sample_q <= 1'b1;
    end
    else if (turn_on_ok)
      low_supply_level <= ~supply_polarity_select;
    // Compare real samples only, so turn-on loading never raises it
    if (supply_sample_strobe && have_sample_q && (supply_sync_q != prev_sample_q))
      supply_change_flag <= 1'b1;
    else if (status_read && sent_flags_q[2])
      supply_change_flag <= 1'b0;
  end
end

// Minute timebase runs from reset, independent of decoding
always @(posedge core_clk)
begin
  if (rst)
  begin
    minute_count_q <= 36'h000000000;
    minute_tick_flag <= 1'b0;
  end
  else
  begin
    minute_count_q <= minute_event ? 36'h000000000 : minute_count_q + 36'h000000001;
    if (minute_event)
      minute_tick_flag <= 1'b1;
    else if (status_read && sent_flags_q[1])
      minute_tick_flag <= 1'b0;
  end
end

// Overflow flag
always @(posedge core_clk)
begin
  if (rst)
    overflow_flag <= 1'b0;
  else if (overflow)
    overflow_flag <= 1'b1;
  else if (status_read && sent_flags_q[0])
    overflow_flag <= 1'b0;
end

// Host prompt, registered to keep the pin glitch free
always @(posedge core_clk)
begin
  if (rst)
    read_prompt_q <= 1'b0;
  else
    read_prompt_q <= (sync_change_flag & sync_prompt_enable) | (minute_tick_flag & minute_prompt_enable) |
                     supply_change_flag | overflow_flag;
end

endmodule

// >>> testbench/host_spi_model.sv
module host_spi_model
(
  // Clock that paces the host's edges
  input wire logic core_clk,
  // Serial link
  output logic spi_sck,
  output logic spi_cs_n,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 1ps;

  // Link clock stands low and select stays high between words
  initial
  begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
  end

  // One poll: 32 bits MSB first, sampled on each rising sck, 48 ns period
  task automatic poll(output logic [31:0] w);
    @(negedge core_clk);
    spi_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      #24 spi_sck = 1'b1;
      w[i] = spi_miso;
      #24 spi_sck = 1'b0;
    end
    // Select rises only after the last fall so the word counts as done
    #24 spi_cs_n = 1'b1;
    // Return just after a falling edge so a following pulse is never zero wide
    repeat (12) @(negedge core_clk);
  endtask
endmodule

// >>> testbench/pager_status_chk.sv
module pager_status_chk
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial link
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  // Control and status
  input wire logic read_prompt_q,
  input wire logic checksum_pass,
  input wire logic turn_on_req,
  input wire logic turn_off_req,
  input wire logic sync_prompt_enable,
  input wire logic minute_prompt_enable,
  input wire logic decoding_on_q,
  input wire logic enabled_q
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // A data bit stands through the whole sck high phase
  sequence bit_held;
    $stable(spi_miso) [*6];
  endsequence

  sequence sel_start;
    $fell(spi_cs_n);
  endsequence

  // Reset leaves the device disabled, quiet and not prompting
  reset_quiet_a:
    assert property (disable iff (1'b0) rst |=> !read_prompt_q && !decoding_on_q && !enabled_q && !spi_miso_oe)
    else $error("outputs not idle after reset");
  enable_cause_a:
    assert property ($rose(enabled_q) |-> $past(checksum_pass))
    else $error("enable without checksum pass");
  decode_cause_a:
    assert property ($rose(decoding_on_q) |-> $past(turn_on_req && enabled_q))
    else $error("decoding started without enabled turn-on");
  select_drive_a:
    assert property (sel_start |-> ##[1:4] spi_miso_oe)
    else $error("miso not driven after select");
  release_idle_a:
    assert property (spi_cs_n [*5] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  bit_stand_a:
    assert property ($rose(spi_sck) && !spi_cs_n |=> bit_held)
    else $error("miso changed during sck high");
  // Flags only clear by a completed read, so a prompt drop needs a select
  prompt_clear_a:
    assert property ($fell(read_prompt_q) && sync_prompt_enable == $past(sync_prompt_enable, 3)
      && minute_prompt_enable == $past(minute_prompt_enable, 3) |-> !$past(spi_cs_n, 4))
    else $error("prompt dropped without a read");
  overflow_prompt_a:
    assert property ($fell(decoding_on_q) && !$past(turn_off_req) |-> ##[0:2] read_prompt_q)
    else $error("overflow stop without prompt");
endmodule

bind pager_host_packet_status pager_status_chk u_chk
(
  .core_clk(core_clk),
  .rst(rst),
  .spi_sck(spi_sck),
  .spi_cs_n(spi_cs_n),
  .spi_miso(spi_miso),
  .spi_miso_oe(spi_miso_oe),
  .read_prompt_q(read_prompt_q),
  .checksum_pass(checksum_pass),
  .turn_on_req(turn_on_req),
  .turn_off_req(turn_off_req),
  .sync_prompt_enable(sync_prompt_enable),
  .minute_prompt_enable(minute_prompt_enable),
  .decoding_on_q(decoding_on_q),
  .enabled_q(enabled_q)
);

// >>> testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Identity values are arbitrary
  localparam logic [1:0] MODEL = 2'h3;
  localparam logic [13:0] COMPAT = 14'h1234;
  localparam logic [7:0] REV = 8'hA5;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic vec_valid = 1'b0, vec_has_msgs = 1'b0, msg_valid = 1'b0, msg_errors_gt2 = 1'b0;
  logic sync_gained = 1'b0, frame_info_good = 1'b0, block0_end = 1'b0, checksum_pass = 1'b0;
  logic sync_lost = 1'b0, turn_off_req = 1'b0;
  logic low_supply_input = 1'b0, supply_sample_strobe = 1'b0, turn_on_req = 1'b0;
  logic sync_prompt_enable = 1'b0, minute_prompt_enable = 1'b1, supply_polarity_select = 1'b0;
  logic [31:0] vec_packet = 32'h0;
  logic [6:0] word_index = 7'h0;
  logic [20:0] msg_info = 21'h0;
  logic [6:0] frame_number_in = 7'h0;
  logic [3:0] cycle_number_in = 4'h0;
  wire spi_sck, spi_cs_n, spi_miso, spi_miso_oe, read_prompt_q, decoding_on_q, enabled_q;
  int fail_count = 0;
  int n_tests = 0;

  always #2 core_clk = ~core_clk;

  // Small queue and short minute keep overflow and timeout reachable
  pager_host_packet_status #(.TXQ_DEPTH(4), .TXQ_ADDR(2), .MINUTE_CYCLES(36'd9000),
    .MODEL_VALUE(MODEL), .COMPAT_VALUE(COMPAT), .REVISION_VALUE(REV)) dut
  (
    .core_clk(core_clk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .read_prompt_q(read_prompt_q), .vec_valid(vec_valid),
    .vec_packet(vec_packet), .vec_has_msgs(vec_has_msgs), .msg_valid(msg_valid), .word_index(word_index),
    .msg_info(msg_info), .msg_errors_gt2(msg_errors_gt2), .sync_gained(sync_gained), .sync_lost(sync_lost),
    .search_window_expired(1'b0), .frame_info_good(frame_info_good), .block0_end(block0_end),
    .frame_number_in(frame_number_in), .cycle_number_in(cycle_number_in),
    .low_supply_input(low_supply_input), .supply_sample_strobe(supply_sample_strobe),
    .checksum_pass(checksum_pass), .turn_on_req(turn_on_req), .turn_off_req(turn_off_req),
    .sync_prompt_enable(sync_prompt_enable), .minute_prompt_enable(minute_prompt_enable),
    .supply_polarity_select(supply_polarity_select), .decoding_on_q(decoding_on_q), .enabled_q(enabled_q)
  );

  host_spi_model host (.core_clk(core_clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso));

  // Masked compare; an unknown bit never matches
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got, logic [31:0] m);
    n_tests++;
    if ((got & m) !== (exp & m))
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp & m, got & m);
    end
  endtask

  task automatic rd(string nm, logic [31:0] exp, logic [31:0] m);
    logic [31:0] w;
    host.poll(w);
    chk(nm, exp, w, m);
  endtask

  // One-cycle pulse, entered at a falling edge
  task automatic tick(ref logic s);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    rd("ident", {8'hFF, MODEL, COMPAT, REV}, 32'hFFFF_FFFF);
    tick(checksum_pass);
    tick(turn_on_req);
    // Frame and cycle fields are undefined until frame info is valid
    rd("status", 32'h7F00_4000, 32'hFF80_C0FF);
    low_supply_input = 1'b1;
    repeat (4) @(negedge core_clk);
    tick(supply_sample_strobe);
    low_supply_input = 1'b0;
    repeat (4) @(negedge core_clk);
    tick(supply_sample_strobe);
    frame_number_in = 7'h2A;
    cycle_number_in = 4'h9;
    tick(sync_gained);
    tick(frame_info_good);
    tick(block0_end);
    @(negedge core_clk);
    chk("prompt", 32'h1, {31'h0, read_prompt_q}, 32'h1);
    rd("status", 32'h7FAA_89C0, 32'hFFFF_FFFF);
    // Good vector opens the gate; the errored one closes it
    vec_has_msgs = 1'b1;
    msg_info = 21'h1ABCDE;
    msg_errors_gt2 = 1'b1;
    vec_packet = 32'h0201_0007;
    tick(vec_valid);
    word_index = 7'h03;
    tick(msg_valid);
    vec_packet = 32'h0881_0007;
    tick(vec_valid);
    word_index = 7'h09;
    tick(msg_valid);
    rd("vector", 32'h0201_0007, 32'hFFFF_FFFF);
    rd("message", 32'h039A_BCDE, 32'hFF9F_FFFF);
    rd("vector", 32'h0881_0007, 32'hFFFF_FFFF);
    rd("status", 32'h7F00_0000, 32'hFF00_00FF);
    chk("prompt", 32'h0, {31'h0, read_prompt_q}, 32'h1);
    // Five pushes into a four-entry queue with no reads
    vec_valid = 1'b1;
    repeat (5) @(negedge core_clk);
    vec_valid = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("decoding", 32'h0, {31'h0, decoding_on_q}, 32'h1);
    chk("prompt", 32'h1, {31'h0, read_prompt_q}, 32'h1);
    rd("status", 32'h7F00_0001, 32'hFF00_00FF);
    for (int k = 0; k < 20000 && read_prompt_q !== 1'b1; k++)
      @(negedge core_clk);
    chk("minute prompt", 32'h1, {31'h0, read_prompt_q}, 32'h1);
    rd("status", 32'h7F00_0010, 32'hFF00_00FF);
    // Second turn-on: sync found with frame info, then sync lost, then turn-off
    tick(turn_on_req);
    tick(sync_gained);
    tick(frame_info_good);
    tick(block0_end);
    @(negedge core_clk);
    chk("sync prompt off", 32'h0, {31'h0, read_prompt_q}, 32'h1);
    sync_prompt_enable = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("sync prompt on", 32'h1, {31'h0, read_prompt_q}, 32'h1);
    rd("status", 32'h7FAA_C980, 32'hFFFF_FFFF);
    tick(sync_lost);
    rd("status", 32'h7F00_4080, 32'hFF80_C0FF);
    tick(turn_off_req);
    chk("decoding", 32'h0, {31'h0, decoding_on_q}, 32'h1);
    rd("status", 32'h7F00_0000, 32'hFF80_80FF);
    finish_test();
  end
endmodule
